// [inc/phc_map.svh]
// Register offsets, field positions, reset values and counts of the packet handler config
`ifndef PHC_MAP_SVH
`define PHC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PHC_OFS_FRAMING 8'h37
`define PHC_OFS_PLEN 8'h38
`define PHC_OFS_OWN 8'h39
`define PHC_OFS_GROUP 8'h3A
`define PHC_OFS_AUTO 8'h3B
`define PHC_OFS_THRESH 8'h3C
`define PHC_OFS_RESTART 8'h3D
`define PHC_OFS_KEY_TOP 8'h3E
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PHC_RST_FRAMING 8'h10
`define PHC_RST_PLEN 8'h40
`define PHC_RST_ADDR 8'h00
`define PHC_RST_AUTO 8'h00
`define PHC_RST_THRESH 8'h8F
`define PHC_RST_RESTART 8'h02
`define PHC_RST_KEY 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PHC_B_FMT 7
`define PHC_B_CRC_ON 4
`define PHC_B_CRC_POL 3
`define PHC_B_TX_START 7
`define PHC_B_RESTART 2
`define PHC_B_AUTO_RST 1
`define PHC_B_CIPHER 0
// ----------------------------------------
// Counts and limits
// ----------------------------------------
`define PHC_CIPHER_MAX_LEN 8'h42
`define PHC_DELAY_ZERO 4'hC
`endif

// [inc/phc_pkg.sv]
// Types of the packet handler config block
package phc_pkg;
   // Auto-mode sequencer
   typedef enum logic [0:0] {AUTO_IDLE, AUTO_INTERIM} phc_auto_t;
   // Receive restart sequencer
   typedef enum logic [1:0] {RS_IDLE, RS_ARMED, RS_WAIT} phc_rs_t;
   // Receive datapath events
   typedef struct packed {
      logic done;
      logic crc_good;
      logic addr_valid;
      logic [7:0] addr;
      logic len_valid;
      logic [7:0] len;
   } phc_rx_evt_t;
   // Whole state of the block
   typedef struct packed {
      logic [7:0] framing;
      logic [7:0] plen;
      logic [7:0] own;
      logic [7:0] group;
      logic [7:0] autom;
      logic [7:0] thresh;
      logic [7:0] restart;
      logic [7:0] key_top;
      logic [7:0] rdata;
      logic has;
      logic lvl;
      logic pld;
      logic crcp;
      logic sync_p;
      logic sent_p;
      logic txs;
      logic flush;
      logic rrst;
      logic [7:0] lim;
      phc_auto_t am;
      logic active;
      phc_rs_t rs;
      logic [11:0] cnt;
   } phc_state_t;
endpackage

// [rtl/phc_core.sv]
// Packet handler configuration registers, flags and sequencers
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "phc_map.svh"

// Notes on behaviour
// - Framing bit 0 selects fixed length, 1 variable; reset is fixed.
// - Line coding 00 none, 01 Manchester, 10 whitening; 11 reserved.
// - Checksum enable, reset on, turns CRC append and check on.
// - Policy 0: failed CRC flushes FIFO, restarts receive, no payload-complete.
// - Policy 1: failed CRC keeps FIFO and still raises payload-complete.
// - Address filter: 00 off, 01 own id, 10 own or group id.
// - Own and group ids are 8-bit, reset zero, compared with address byte.
// - Fixed framing: length register is exact payload length, reset 64.
// - Variable framing: length register is receive maximum only.
// - Entry trigger 000 off, 001-101 rising flag edges, 110 FIFO empty.
// - Exit trigger: empty, flag edges or timeout, sent edge, timeout alone.
// - Interim mode 00 sleep, 01 standby, 10 receive, 11 transmit.
// - Transmit starts on level flag if select 0, on any byte if 1.
// - Seven-bit threshold, reset fifteen, drives the level flag.
// - Delay after FIFO empty is 2^field bit times, zero from 12.
// - Restart strobe forces receive wait in continuous mode; reads zero.
// - Auto restart on: restart after delay once payload read out.
// - Cipher enable turns on AES; payloads limited to 66 bytes.
// - Top key byte is write-only, reset zero, key bits 127:120.
// - Level flag set when count strictly exceeds threshold.
// - Payload-complete set after last byte unless CRC fails under policy 0; cleared on empty.
module phc_core
   import phc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   input wire logic [6:0] fifo_count_i,
   input wire logic bit_tick_i,
   input wire phc_rx_evt_t rx_evt_i,
   input wire logic sync_match_i,
   input wire logic frame_sent_i,
   input wire logic timeout_i,
   input wire logic continuous_rx_i,
   output logic framing_format_o,
   output logic [1:0] line_coding_select_o,
   output logic checksum_enable_o,
   output logic [7:0] frame_length_value_o,
   output logic [7:0] payload_limit_o,
   output logic cipher_enable_o,
   output logic [7:0] cipher_key_top_o,
   output logic queue_has_data_flag_o,
   output logic queue_above_threshold_flag_o,
   output logic payload_complete_flag_o,
   output logic checksum_pass_flag_o,
   output logic transmit_start_o,
   output logic flush_o,
   output logic rx_restart_o,
   output logic interim_active_o,
   output logic [1:0] interim_operating_mode_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Bit ticks to wait; zero means restart at once
   function automatic logic [11:0] phc_delay_ticks(input logic [3:0] f);
      logic [11:0] t;
      t = 12'h000;
      if (f < `PHC_DELAY_ZERO) begin
         t = 12'h001 << f;
      end
      return t;
   endfunction

   phc_state_t q, d;
   logic crc_on, crc_pol, fmt;
   logic has_r, has_f, lvl_r, crc_r, pld_r, sync_r, sent_r;
   logic crc_fail, addr_ok, len_bad, enter_hit, exit_hit;
   logic [2:0] ent, ext;
   logic [1:0] filt;
   logic [11:0] ticks;

   // Field views of the stored registers
   assign fmt = q.framing[`PHC_B_FMT];
   assign crc_on = q.framing[`PHC_B_CRC_ON];
   assign crc_pol = q.framing[`PHC_B_CRC_POL];
   assign filt = q.framing[2:1];
   assign ent = q.autom[7:5];
   assign ext = q.autom[4:2];
   assign ticks = phc_delay_ticks(q.restart[7:4]);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.flush = 1'b0;
      d.rrst = 1'b0;
      d.rdata = 8'h00;
      // Register writes
      if (we_i) begin
         case (addr_i)
            `PHC_OFS_FRAMING: d.framing = wdata_i;
            `PHC_OFS_PLEN: d.plen = wdata_i;
            `PHC_OFS_OWN: d.own = wdata_i;
            `PHC_OFS_GROUP: d.group = wdata_i;
            `PHC_OFS_AUTO: d.autom = wdata_i;
            `PHC_OFS_THRESH: d.thresh = wdata_i;
            `PHC_OFS_RESTART: d.restart = {wdata_i[7:3], 1'b0, wdata_i[1:0]};
            `PHC_OFS_KEY_TOP: d.key_top = wdata_i;
            default: ;
         endcase
      end
      // Register reads; strobe and key read as zero
      if (re_i) begin
         case (addr_i)
            `PHC_OFS_FRAMING: d.rdata = q.framing;
            `PHC_OFS_PLEN: d.rdata = q.plen;
            `PHC_OFS_OWN: d.rdata = q.own;
            `PHC_OFS_GROUP: d.rdata = q.group;
            `PHC_OFS_AUTO: d.rdata = q.autom;
            `PHC_OFS_THRESH: d.rdata = q.thresh;
            `PHC_OFS_RESTART: d.rdata = q.restart;
            default: d.rdata = 8'h00;
         endcase
      end
      // Queue flags from the FIFO count
      d.has = (fifo_count_i != 7'h00);
      d.lvl = (fifo_count_i > q.thresh[6:0]);
      // Cipher caps the usable payload
      d.lim = q.plen;
      if (q.restart[`PHC_B_CIPHER] && (q.plen > `PHC_CIPHER_MAX_LEN)) begin
         d.lim = `PHC_CIPHER_MAX_LEN;
      end
      // Address filter on the received address byte
      case (filt)
         2'b01: addr_ok = (rx_evt_i.addr == q.own);
         2'b10: addr_ok = (rx_evt_i.addr == q.own) || (rx_evt_i.addr == q.group);
         default: addr_ok = 1'b1;
      endcase
      if (rx_evt_i.addr_valid && !addr_ok) begin
         d.flush = 1'b1;
         d.rrst = 1'b1;
      end
      // Length byte only checked in variable framing
      len_bad = fmt && rx_evt_i.len_valid && (rx_evt_i.len > q.lim);
      if (len_bad) begin
         d.flush = 1'b1;
         d.rrst = 1'b1;
      end
      // Completion and checksum outcome
      crc_fail = crc_on && !rx_evt_i.crc_good;
      if (!d.has) begin
         d.pld = 1'b0;
         d.crcp = 1'b0;
      end
      if (rx_evt_i.done) begin
         if (crc_on && rx_evt_i.crc_good) begin
            d.crcp = 1'b1;
         end
         if (crc_fail && !crc_pol) begin
            d.flush = 1'b1;
            d.rrst = 1'b1;
         end else begin
            d.pld = 1'b1;
         end
      end
      // Transmit start condition
      d.txs = q.thresh[`PHC_B_TX_START] ? d.has : d.lvl;
      // Edges seen by the auto sequencer
      d.sync_p = sync_match_i;
      d.sent_p = frame_sent_i;
      has_r = d.has && !q.has;
      has_f = !d.has && q.has;
      lvl_r = d.lvl && !q.lvl;
      crc_r = d.crcp && !q.crcp;
      pld_r = d.pld && !q.pld;
      sync_r = sync_match_i && !q.sync_p;
      sent_r = frame_sent_i && !q.sent_p;
      // Entry trigger; 110 taken as the FIFO going empty
      case (ent)
         3'b001: enter_hit = has_r;
         3'b010: enter_hit = lvl_r;
         3'b011: enter_hit = crc_r;
         3'b100: enter_hit = pld_r;
         3'b101: enter_hit = sync_r;
         3'b110: enter_hit = has_f;
         default: enter_hit = 1'b0;
      endcase
      // Exit trigger
      case (ext)
         3'b001: exit_hit = has_f;
         3'b010: exit_hit = lvl_r || timeout_i;
         3'b011: exit_hit = crc_r || timeout_i;
         3'b100: exit_hit = pld_r || timeout_i;
         3'b101: exit_hit = sync_r || timeout_i;
         3'b110: exit_hit = sent_r;
         3'b111: exit_hit = timeout_i;
         default: exit_hit = 1'b0;
      endcase
      // Auto-mode sequencer; either trigger at zero turns it off
      case (q.am)
         AUTO_IDLE: begin
            if (enter_hit && (ext != 3'b000)) begin
               d.am = AUTO_INTERIM;
            end
         end
         AUTO_INTERIM: begin
            if (exit_hit || (ent == 3'b000) || (ext == 3'b000)) begin
               d.am = AUTO_IDLE;
            end
         end
         default: d.am = AUTO_IDLE;
      endcase
      d.active = (d.am == AUTO_INTERIM);
      // Receive restart after the payload is read out
      case (q.rs)
         RS_IDLE: begin
            if (pld_r && q.restart[`PHC_B_AUTO_RST]) begin
               d.rs = RS_ARMED;
            end
         end
         RS_ARMED: begin
            if (!q.restart[`PHC_B_AUTO_RST]) begin
               d.rs = RS_IDLE;
            end else if (!d.has) begin
               d.rs = RS_WAIT;
               d.cnt = 12'h000;
            end
         end
         RS_WAIT: begin
            if (!q.restart[`PHC_B_AUTO_RST]) begin
               d.rs = RS_IDLE;
            end else if (q.cnt >= ticks) begin
               d.rrst = 1'b1;
               d.rs = RS_IDLE;
            end else if (bit_tick_i) begin
               d.cnt = q.cnt + 12'h001;
            end
         end
         default: d.rs = RS_IDLE;
      endcase
      // Manual strobe only acts in continuous receive
      if (we_i && (addr_i == `PHC_OFS_RESTART) && wdata_i[`PHC_B_RESTART] && continuous_rx_i) begin
         d.rrst = 1'b1;
      end
   end

   // ----------------------------------------
   // State register, frozen while ce_i is low
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '0;
         q.framing <= `PHC_RST_FRAMING;
         q.plen <= `PHC_RST_PLEN;
         q.own <= `PHC_RST_ADDR;
         q.group <= `PHC_RST_ADDR;
         q.autom <= `PHC_RST_AUTO;
         q.thresh <= `PHC_RST_THRESH;
         q.restart <= `PHC_RST_RESTART;
         q.key_top <= `PHC_RST_KEY;
         q.lim <= `PHC_RST_PLEN;
         q.am <= AUTO_IDLE;
         q.rs <= RS_IDLE;
      end else if (ce_i) begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs, all straight from the state
   // ----------------------------------------
   assign rdata_o = q.rdata;
   assign framing_format_o = fmt;
   assign line_coding_select_o = q.framing[6:5];
   assign checksum_enable_o = crc_on;
   assign frame_length_value_o = q.plen;
   assign payload_limit_o = q.lim;
   assign cipher_enable_o = q.restart[`PHC_B_CIPHER];
   assign cipher_key_top_o = q.key_top;
   assign queue_has_data_flag_o = q.has;
   assign queue_above_threshold_flag_o = q.lvl;
   assign payload_complete_flag_o = q.pld;
   assign checksum_pass_flag_o = q.crcp;
   assign transmit_start_o = q.txs;
   assign flush_o = q.flush;
   assign rx_restart_o = q.rrst;
   assign interim_active_o = q.active;
   assign interim_operating_mode_o = q.autom[1:0];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_crc_fail;
      ce_i && rx_evt_i.done && crc_on && !rx_evt_i.crc_good;
   endsequence

   property p_level;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i |=> queue_above_threshold_flag_o == ($past(fifo_count_i) > $past(q.thresh[6:0]));
   endproperty
   a_level: assert property (p_level) else $error("level flag wrong");

   property p_crc_drop;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      s_crc_fail and !crc_pol and !q.pld |=> flush_o && rx_restart_o && !payload_complete_flag_o;
   endproperty
   a_crc_drop: assert property (p_crc_drop) else $error("failed crc not dropped");

   property p_crc_keep;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      s_crc_fail and crc_pol |=> payload_complete_flag_o && !flush_o;
   endproperty
   a_crc_keep: assert property (p_crc_keep) else $error("failed crc not kept");

   property p_empty_clear;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && fifo_count_i == 7'h00 && !rx_evt_i.done |=> !payload_complete_flag_o;
   endproperty
   a_empty_clear: assert property (p_empty_clear) else $error("flag not cleared");

   property p_strobe_read;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && re_i && addr_i == `PHC_OFS_RESTART |=> rdata_o[`PHC_B_RESTART] == 1'b0;
   endproperty
   a_strobe_read: assert property (p_strobe_read) else $error("strobe reads one");

   property p_key_read;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && re_i && addr_i == `PHC_OFS_KEY_TOP |=> rdata_o == 8'h00;
   endproperty
   a_key_read: assert property (p_key_read) else $error("key readable");

   property p_tx_start;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && q.thresh[`PHC_B_TX_START] |=> transmit_start_o == ($past(fifo_count_i) != 7'h00);
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("tx start wrong");

   property p_filter;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && rx_evt_i.addr_valid && filt == 2'b01 && rx_evt_i.addr != q.own |=> flush_o;
   endproperty
   a_filter: assert property (p_filter) else $error("address not filtered");

   property p_no_auto;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && !q.restart[`PHC_B_AUTO_RST] && !we_i && !rx_evt_i.addr_valid && !rx_evt_i.done
         && !rx_evt_i.len_valid |=> !rx_restart_o;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("restart while off");

   // Broadcast filtering drops a frame that matches neither id
   property p_group_filter;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && rx_evt_i.addr_valid && filt == 2'b10 && rx_evt_i.addr != q.own
         && rx_evt_i.addr != q.group |=> flush_o && rx_restart_o;
   endproperty
   a_group_filter: assert property (p_group_filter) else $error("group filter missed");

   // The cipher cap must never let a longer payload through
   property p_cipher_cap;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && cipher_enable_o |=> payload_limit_o <= `PHC_CIPHER_MAX_LEN;
   endproperty
   a_cipher_cap: assert property (p_cipher_cap) else $error("cipher cap exceeded");

   // Timeout alone ends the interim mode
   property p_timeout_exit;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && q.am == AUTO_INTERIM && ext == 3'b111 && timeout_i |=> !interim_active_o;
   endproperty
   a_timeout_exit: assert property (p_timeout_exit) else $error("timeout exit missed");

   // Over-long length byte in variable framing drops the frame
   property p_len_cap;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && fmt && rx_evt_i.len_valid && rx_evt_i.len > q.lim |=> flush_o;
   endproperty
   a_len_cap: assert property (p_len_cap) else $error("long frame kept");

   // Large delay codes restart with no wait at all
   property p_delay_zero;
      @(posedge ref_clk_i) disable iff (!rstn_i)
      ce_i && q.rs == RS_WAIT && q.restart[`PHC_B_AUTO_RST]
         && q.restart[7:4] >= `PHC_DELAY_ZERO |=> rx_restart_o;
   endproperty
   a_delay_zero: assert property (p_delay_zero) else $error("zero delay not taken");

endmodule // phc_core

// [tb/phc_peer.sv]
// Remote radio peer: delivers one received frame as address, length and end beats
`timescale 1ns/1ps
module phc_peer
   import phc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic go_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] len_i,
   input wire logic crc_i,
   input wire logic stop_i,
   output phc_rx_evt_t evt_o
);
   logic [1:0] step_q = 2'h0;
   // ------
   // Frame beats
   // ------
   // Address, length, then end of frame, one beat each, back to idle
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) step_q <= 2'h0;
      else if (stop_i) step_q <= 2'h0;
      else if (go_i || step_q != 2'h0) step_q <= step_q + 2'h1;
   end
   // Off-beat fields carry inverted data, never a stale copy
   assign evt_o.addr_valid = step_q == 2'h1;
   assign evt_o.len_valid = step_q == 2'h2;
   // A receive restart abandons the frame, so its end never arrives
   assign evt_o.done = step_q == 2'h3 && !stop_i;
   assign evt_o.addr = evt_o.addr_valid ? addr_i : ~addr_i;
   assign evt_o.len = evt_o.len_valid ? len_i : ~len_i;
   assign evt_o.crc_good = evt_o.done ? crc_i : ~crc_i;
endmodule // phc_peer

// [tb/phc_core_tb.sv]
// Self-checking bench of the packet handler config block
`timescale 1ns/1ps
module phc_core_tb
   import phc_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic ce_i = 1'b1;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic bit_tick_i = 1'b0;
   logic continuous_rx_i = 1'b0;
   logic go = 1'b0;
   logic pc = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] pa = 8'h00;
   logic [7:0] pl = 8'h00;
   logic [6:0] fifo_count_i = 7'h00;
   phc_rx_evt_t rx_evt_i;
   logic [7:0] rdata_o, frame_length_value_o, payload_limit_o, cipher_key_top_o;
   logic [1:0] line_coding_select_o, interim_operating_mode_o;
   logic framing_format_o, checksum_enable_o, cipher_enable_o, queue_has_data_flag_o;
   logic queue_above_threshold_flag_o, payload_complete_flag_o, checksum_pass_flag_o;
   logic transmit_start_o, flush_o, rx_restart_o, interim_active_o;
   int fail_count = 0;
   int compares = 0;
   int seed = 53157;
   int cycles = 0;
   logic [7:0] m [8];
   // Frame cases: config, address, length, crc, payload flag, flush (F = not judged)
   logic [35:0] rt [10] = '{36'h10_5A_10_0_0_1, 36'h18_5A_10_0_1_0, 36'h00_5A_10_0_1_0,
      36'h12_5A_10_1_1_0, 36'h12_C3_10_1_0_F, 36'h14_C3_10_1_1_0, 36'h14_11_10_1_0_F,
      36'h90_11_42_1_1_0, 36'h90_11_43_1_0_F, 36'h00_11_60_1_1_0};
   logic [7:0] rs [5] = '{8'h02, 8'h52, 8'hB2, 8'hC2, 8'h50};

   phc_core dut_u (.ref_clk_i, .rstn_i, .ce_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
      .fifo_count_i, .bit_tick_i, .rx_evt_i, .sync_match_i(ev[0]), .frame_sent_i(ev[1]),
      .timeout_i(ev[2]), .continuous_rx_i, .framing_format_o, .line_coding_select_o,
      .checksum_enable_o, .frame_length_value_o, .payload_limit_o, .cipher_enable_o,
      .cipher_key_top_o, .queue_has_data_flag_o, .queue_above_threshold_flag_o,
      .payload_complete_flag_o, .checksum_pass_flag_o, .transmit_start_o, .flush_o,
      .rx_restart_o, .interim_active_o, .interim_operating_mode_o);
   phc_peer peer_u (.ref_clk_i, .rstn_i, .go_i(go), .addr_i(pa), .len_i(pl), .crc_i(pc),
      .stop_i(rx_restart_o), .evt_o(rx_evt_i));

   // ------
   // Clock, bit tick and hang guard
   // ------
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // Tick every other cycle so the delay count is not a plain cycle count
   always @(posedge ref_clk_i) bit_tick_i <= ~bit_tick_i;
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         print_verdict();
      end
   end

   // ------
   // Shared tasks
   // ------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string s, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", s, exp, got);
      end
   endtask
   // Write; the model follows only when the enable lets the write in
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge ref_clk_i);
      we_i <= 1'b0;
      if (ce_i === 1'b1) m[a - 8'h37] = d;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge ref_clk_i);
      re_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic chk_regs();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         rd(8'h37 + i[7:0], d);
         check($sformatf("reg %0h", i), d, i == 7 ? 8'h00 : i == 6 ? m[6] & 8'hFB : m[i]);
      end
   endtask
   task automatic chk_out();
      check("format", framing_format_o, m[0][7]);
      check("coding", line_coding_select_o, m[0][6:5]);
      check("crc on", checksum_enable_o, m[0][4]);
      check("length", frame_length_value_o, m[1]);
      check("cipher", cipher_enable_o, m[6][0]);
      check("key", cipher_key_top_o, m[7]);
      check("limit", payload_limit_o, (m[6][0] && m[1] > 8'h42) ? 8'h42 : m[1]);
   endtask
   task automatic setc(input logic [6:0] v, input int w);
      @(posedge ref_clk_i);
      fifo_count_i <= v;
      repeat (w) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic pulse(input int b);
      @(posedge ref_clk_i);
      ev[b] <= 1'b1;
      @(posedge ref_clk_i);
      ev[b] <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask
   // Peer frame; returns in the cycle after the end beat is taken
   task automatic rx(input logic [7:0] a, input logic [7:0] l, input logic c);
      @(posedge ref_clk_i);
      go <= 1'b1;
      pa <= a;
      pl <= l;
      pc <= c;
      @(posedge ref_clk_i);
      go <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask

   // ------
   // Main sequence
   // ------
   initial begin
      logic [7:0] d;
      logic [6:0] c;
      int n;
      int f;
      int lo;
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      m = '{8'h10, 8'h40, 8'h00, 8'h00, 8'h00, 8'h8F, 8'h02, 8'h00};
      chk_regs();
      chk_out();
      rd(8'h36, d);
      check("unmapped", d, 8'h00);
      // Random contents, reserved codes kept out
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            if (i == 0 && d[6:5] == 2'h3) d[6] = 1'b0;
            if (i == 0 && d[2:1] == 2'h3) d[2] = 1'b0;
            wr(8'h37 + i[7:0], d);
         end
         chk_regs();
         chk_out();
      end
      for (int k = 0; k < 3; k++) begin
         wr(8'h37, {1'b0, k[1:0], 5'h00});
         check("coding", line_coding_select_o, k[1:0]);
      end
      wr(8'h3B, 8'h00);
      // Level flags and start condition against random thresholds
      for (int i = 0; i < 24; i++) begin
         d = 8'($random(seed));
         c = 7'($random(seed));
         if (i % 4 == 0) c = d[6:0];
         wr(8'h3C, d);
         setc(c, 3);
         check("has data", queue_has_data_flag_o, c != 7'h00);
         check("level", queue_above_threshold_flag_o, c > d[6:0]);
         check("tx start", transmit_start_o, d[7] ? c != 7'h00 : c > d[6:0]);
      end
      // Write with the clock enable low is not taken
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      wr(8'h39, 8'hA5);
      @(posedge ref_clk_i);
      ce_i <= 1'b1;
      chk_regs();
      // Manual restart only in continuous receive
      for (int k = 1; k >= 0; k--) begin
         @(posedge ref_clk_i);
         continuous_rx_i <= k[0];
         wr(8'h3D, 8'h04);
         check("manual", rx_restart_o, k[0]);
      end
      chk_regs();
      // Received frames through the peer
      wr(8'h39, 8'h5A);
      wr(8'h3A, 8'hC3);
      wr(8'h38, 8'h50);
      wr(8'h3D, 8'h01);
      foreach (rt[i]) begin
         wr(8'h37, rt[i][35:28]);
         setc(7'h0A, 1);
         rx(rt[i][27:20], rt[i][19:12], rt[i][8]);
         check("payload", payload_complete_flag_o, rt[i][4]);
         if (rt[i][3:0] != 4'hF) check("flush", flush_o, rt[i][0]);
         check("crc pass", checksum_pass_flag_o, rt[i][4] & rt[i][32] & rt[i][8]);
         setc(7'h00, 3);
         check("cleared", payload_complete_flag_o, 1'b0);
      end
      // Automatic restart after the inter-frame delay
      wr(8'h37, 8'h00);
      foreach (rs[i]) begin
         wr(8'h3D, rs[i]);
         setc(7'h0A, 1);
         rx(8'h00, 8'h10, 1'b1);
         setc(7'h00, 0);
         n = 0;
         while (rx_restart_o !== 1'b1 && n < 5000) begin
            @(posedge ref_clk_i);
            #1;
            n++;
         end
         f = rs[i][7:4];
         lo = f < 12 ? (2 << f) - 1 : 0;
         check("auto seen", n < (rs[i][1] ? 5000 : 300), rs[i][1]);
         if (rs[i][1]) check("auto delay", n >= lo && n <= lo + 9, 1'b1);
      end
      // Intermediate mode sequencer
      wr(8'h3B, 8'h04);
      setc(7'h05, 3);
      check("no entry", interim_active_o, 1'b0);
      setc(7'h00, 3);
      wr(8'h3B, 8'h26);
      setc(7'h05, 3);
      check("enter", {interim_active_o, interim_operating_mode_o}, 8'h06);
      setc(7'h00, 3);
      check("exit", interim_active_o, 1'b0);
      wr(8'h3B, 8'hDF);
      setc(7'h05, 3);
      setc(7'h00, 3);
      check("enter", {interim_active_o, interim_operating_mode_o}, 8'h07);
      pulse(2);
      check("exit", interim_active_o, 1'b0);
      wr(8'h3B, 8'hB9);
      pulse(0);
      check("enter", {interim_active_o, interim_operating_mode_o}, 8'h05);
      pulse(1);
      check("exit", interim_active_o, 1'b0);
      print_verdict();
   end
endmodule // phc_core_tb
